// *** hdl/sarhp_pkg.sv ***
package sarhp_pkg;
    // ==========================================
    // widths
    localparam int unsigned RES_BITS = 12;
    localparam int unsigned LANE_BITS = 8;

    // ==========================================
    // timing (clock 20 MHz)
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 50;
    // conversion time, typical, in ns
    localparam int unsigned CONV_TIME_NS = 6000;
    // cycles per bit step: 6 us / 12 bits, rounded down
    localparam int unsigned STEP_CYCLES =
        CONV_TIME_NS / (CLK_PERIOD_NS * RES_BITS);
    // first bit decision is held off by this time after start
    localparam int unsigned FIRST_DECIDE_NS = 400;
    localparam int unsigned FIRST_DECIDE_CYCLES =
        FIRST_DECIDE_NS / CLK_PERIOD_NS;
    // nap wake-up, least time, in ns (rounded up)
    localparam int unsigned NAP_WAKE_NS = 620;
    localparam int unsigned NAP_WAKE_CYCLES =
        (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reference settle after sleep, in us
    localparam int unsigned REF_SETTLE_BIG_US = 4200;
    localparam int unsigned REF_SETTLE_SMALL_US = 3300;
    localparam int unsigned REF_SETTLE_BIG_CYCLES =
        REF_SETTLE_BIG_US * (CLK_HZ / 1_000_000);
    localparam int unsigned REF_SETTLE_SMALL_CYCLES =
        REF_SETTLE_SMALL_US * (CLK_HZ / 1_000_000);
    localparam int unsigned REF_CNT_BITS = 17;

    // ==========================================
    // reset values
    localparam logic [11:0] APPROX_RST = 12'h000;
    localparam logic [11:0] RESULT_RST = 12'h000;

    // conversion state machine, gray along start->decide->done
    typedef enum logic [1:0] {
        SARHP_IDLE = 2'b00,
        SARHP_HOLD = 2'b01,
        SARHP_DECIDE = 2'b11,
        SARHP_DONE = 2'b10
    } sarhp_state_e;
endpackage

// *** hdl/sarhp_out_drive.sv ***
`timescale 1ns/10ps
// output lane driver for both output variants
module sarhp_out_drive
    import sarhp_pkg::*;
(
    input wire logic [11:0] result, // latched result
    input wire logic read_en, // cs and rd both low
    input wire logic byte_mode, // 1: byte-read variant
    input wire logic upper_byte_sel, // high byte select
    output logic [11:0] data_out, // output data
    output logic [11:0] data_oe // per-pin output enable
);
    // ==========================================
    // lane selection
    logic [7:0] byte_lanes;
    // high byte puts bits 11..8 on lanes 3..0, upper lanes low
    assign byte_lanes = upper_byte_sel ?
        {4'h0, result[11:8]} : result[7:0];
    // full word: pin eleven is the msb
    assign data_out = byte_mode ?
        {4'h0, byte_lanes} : result;
    // drivers on only while read enabled, else float
    assign data_oe = read_en ?
        (byte_mode ? 12'h0ff : 12'hfff) : 12'h000;
endmodule

// *** hdl/sarhp_ctrl.sv ***
`timescale 1ns/10ps
// Function
// - start conversion on conv_start_n fall while chip select low
// - ignore start and read while chip select high
// - data drivers on only with read and chip select low
// - busy_n low through conversion, rises at completion
// - sleep low enters deep power-down, ref_settled low
// - ref_settled rises after reference settles following sleep release
// - nap low halts conversion; host waits 620ns after nap release
// - byte variant: upper select gives bits 11..8 low lanes, rest low
// - byte variant: straight binary unipolar, offset binary bipolar
// - full-word variant: twelve outputs, pin eleven is msb
// - approx_reg cleared at conversion start before decisions
// - further start edges ignored until conversion completes
// - twelve bits resolved msb first, one per step
// - finished approx_reg copied to output latches, msb inverted in full-word bipolar
// - conversion takes about 6us of internal clock
// - ref_settled rises 4.2ms or 3.3ms after sleep release
module sarhp_ctrl
    import sarhp_pkg::*;
#(
    parameter int unsigned REF_BIG_CYCLES = REF_SETTLE_BIG_CYCLES,
    parameter int unsigned REF_SMALL_CYCLES = REF_SETTLE_SMALL_CYCLES
)(
    input wire logic clock, // 20 MHz clock
    input wire logic rst_n, // sync reset, active low
    input wire logic cs_n, // chip select, active low
    input wire logic conv_start_n, // conversion start, active low
    input wire logic rd_n, // read, active low
    input wire logic sleep_n, // deep power-down, active low
    input wire logic nap_n, // light power-down, active low
    input wire logic upper_byte_sel, // high byte select
    input wire logic byte_mode, // 1: byte-read variant
    input wire logic bipolar, // 1: bipolar input range
    input wire logic big_bypass, // 1: larger reference bypass
    input wire logic comp_above, // comparator: input above dac
    output logic [11:0] dac_code, // trial code to the dac
    output logic busy_n, // low during conversion
    output logic ref_settled, // reference ready
    output logic [11:0] data_out, // output data
    output logic [11:0] data_oe // output enables
);
    // ==========================================
    // state
    sarhp_state_e state;
    logic [11:0] approx_reg;
    logic [11:0] result;
    logic [3:0] bit_idx;
    logic [7:0] step_cnt;
    logic start_prev;
    logic [4:0] nap_cnt;
    logic [REF_CNT_BITS-1:0] ref_cnt;
    logic nap_prev;

    // ==========================================
    // decode
    logic start_fall;
    logic powered;
    logic may_start;
    logic step_done;
    logic read_en;
    logic [REF_CNT_BITS-1:0] ref_target;
    logic [11:0] trial_bit;
    logic [11:0] raw_code;

    // falling start edge counts only with chip select low
    assign start_fall = start_prev & ~conv_start_n & ~cs_n;
    // no start in sleep, nap or before reference settled
    assign powered = sleep_n & nap_n;
    assign may_start = powered & ref_settled;
    // first step waits out the 400ns window, later ones step time
    assign step_done = (state == SARHP_HOLD) ?
        (step_cnt == 8'(FIRST_DECIDE_CYCLES - 1)) :
        (step_cnt == 8'(STEP_CYCLES - 1));
    assign read_en = ~cs_n & ~rd_n;
    assign ref_target = big_bypass ?
        REF_CNT_BITS'(REF_BIG_CYCLES) :
        REF_CNT_BITS'(REF_SMALL_CYCLES);
    assign trial_bit = 12'h800 >> bit_idx;
    assign dac_code = approx_reg | trial_bit;
    // unipolar straight binary; bipolar offset binary in byte variant
    assign raw_code = (byte_mode | ~bipolar) ?
        approx_reg : (approx_reg ^ 12'h800);

    // ==========================================
    // start edge history
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            start_prev <= 1'b1;
            nap_prev <= 1'b1;
        end else begin
            start_prev <= conv_start_n;
            nap_prev <= nap_n;
        end
    end

    // ==========================================
    // reference settle timer after sleep release
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ref_cnt <= '0;
            ref_settled <= 1'b0;
        end else if (!sleep_n) begin
            ref_cnt <= '0;
            ref_settled <= 1'b0;
        end else if (!ref_settled) begin
            if (ref_cnt >= ref_target - 1'b1) begin
                ref_settled <= 1'b1;
            end else begin
                ref_cnt <= ref_cnt + 1'b1;
            end
        end
    end

    // ==========================================
    // nap wake-up: start ignored during wake time except at the first edge after release
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            nap_cnt <= '0;
        end else if (!nap_n) begin
            nap_cnt <= '0;
        end else if (!nap_prev) begin
            nap_cnt <= 5'(NAP_WAKE_CYCLES);
        end else if (nap_cnt != 5'h0) begin
            nap_cnt <= nap_cnt - 1'b1;
        end
    end

    // ==========================================
    // conversion sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= SARHP_IDLE;
            approx_reg <= APPROX_RST;
            bit_idx <= 4'h0;
            step_cnt <= 8'h00;
            busy_n <= 1'b1;
        end else if (!powered) begin
            // power-down stops all activity
            state <= SARHP_IDLE;
            busy_n <= 1'b1;
            step_cnt <= 8'h00;
        end else begin
            case (state)
                SARHP_IDLE: begin
                    if (start_fall && may_start && nap_cnt == 5'h0) begin
                        approx_reg <= APPROX_RST;
                        bit_idx <= 4'h0;
                        step_cnt <= 8'h00;
                        busy_n <= 1'b0;
                        state <= SARHP_HOLD;
                    end
                end
                SARHP_HOLD: begin
                    // start edges ignored while converting
                    step_cnt <= step_done ? 8'h00 : step_cnt + 1'b1;
                    if (step_done) begin
                        state <= SARHP_DECIDE;
                    end
                end
                SARHP_DECIDE: begin
                    step_cnt <= step_done ? 8'h00 : step_cnt + 1'b1;
                    if (step_done) begin
                        // keep trial bit if input is above
                        if (comp_above) begin
                            approx_reg <= approx_reg | trial_bit;
                        end
                        if (bit_idx == 4'd11) begin
                            state <= SARHP_DONE;
                        end else begin
                            bit_idx <= bit_idx + 1'b1;
                        end
                    end
                end
                SARHP_DONE: begin
                    busy_n <= 1'b1;
                    state <= SARHP_IDLE;
                end
                default: begin
                    state <= SARHP_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // output latches load on the edge that raises busy
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result <= RESULT_RST;
        end else if (powered && state == SARHP_DONE) begin
            result <= raw_code;
        end
    end

    // ==========================================
    // output lanes
    sarhp_out_drive u_drive (
        .result(result),
        .read_en(read_en),
        .byte_mode(byte_mode),
        .upper_byte_sel(upper_byte_sel),
        .data_out(data_out),
        .data_oe(data_oe)
    );
endmodule

// *** testbench/sarhp_ctrl_asserts.sv ***
`timescale 1ns/10ps
// ==========================================
// port checker for the converter control
module sarhp_ctrl_asserts
    import sarhp_pkg::*;
#(
    parameter int unsigned REF_BIG_CYCLES = 20,
    parameter int unsigned REF_SMALL_CYCLES = 10
)(
    input wire logic clock, // clock
    input wire logic rst_n, // reset
    input wire logic cs_n, // select
    input wire logic conv_start_n, // start
    input wire logic rd_n, // read
    input wire logic sleep_n, // sleep
    input wire logic nap_n, // nap
    input wire logic upper_byte_sel, // byte select
    input wire logic byte_mode, // variant
    input wire logic bipolar, // range
    input wire logic big_bypass, // bypass
    input wire logic comp_above, // comparator
    input wire logic [11:0] dac_code, // trial code
    input wire logic busy_n, // busy
    input wire logic ref_settled, // ref ready
    input wire logic [11:0] data_out, // data
    input wire logic [11:0] data_oe // enables
);
    logic [7:0] low_cnt;
    logic abrt;
    logic [16:0] hi_cnt;
    logic [16:0] lim;
    assign lim = big_bypass ? 17'(REF_BIG_CYCLES) : 17'(REF_SMALL_CYCLES);
    // busy low time, power-down seen, sleep high time
    always_ff @(posedge clock) begin
        low_cnt <= (!rst_n || busy_n) ? 8'h00 : low_cnt + 8'h01;
        abrt <= (!rst_n || busy_n) ? 1'b0 : (abrt | !sleep_n | !nap_n);
        hi_cnt <= (!rst_n || !sleep_n) ? 17'h0_0000 : hi_cnt + 17'(~&hi_cnt);
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_oe_gate: assert property (
        data_oe == ((cs_n || rd_n) ? 12'h000 : (byte_mode ? 12'h0ff : 12'hfff)))
        else $error("output enable wrong");
    a_start_cause: assert property (
        $fell(busy_n) |-> $past(conv_start_n, 2) && !$past(conv_start_n)
        && !$past(cs_n) && $past(ref_settled)
        && $past(sleep_n) && $past(nap_n)) else $error("bad start");
    a_busy_len: assert property (
        $rose(busy_n) && !abrt |-> low_cnt == 8'h81)
        else $error("busy low time wrong");
    a_no_restart: assert property (low_cnt <= 8'h81)
        else $error("conversion restarted");
    a_sleep_ref: assert property (!sleep_n |=> !ref_settled)
        else $error("ref ready in sleep");
    a_ref_early: assert property (
        ref_settled |-> hi_cnt >= lim - 17'h0_0001)
        else $error("ref ready too soon");
    a_sar_clear: assert property (
        $fell(busy_n) |-> dac_code[10:0] == 11'h000)
        else $error("approx reg not cleared");
    a_msb_first: assert property (
        $fell(busy_n) |-> ##12 dac_code == 12'h800)
        else $error("first trial not msb");
endmodule
bind sarhp_ctrl sarhp_ctrl_asserts #(.REF_BIG_CYCLES(REF_BIG_CYCLES),
    .REF_SMALL_CYCLES(REF_SMALL_CYCLES)) u_sarhp_ctrl_asserts (
    .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
    .conv_start_n(conv_start_n), .sleep_n(sleep_n), .nap_n(nap_n),
    .upper_byte_sel(upper_byte_sel), .byte_mode(byte_mode),
    .bipolar(bipolar), .big_bypass(big_bypass), .comp_above(comp_above),
    .dac_code(dac_code), .busy_n(busy_n), .ref_settled(ref_settled),
    .data_out(data_out), .data_oe(data_oe));

// *** testbench/sarhp_comp_model.sv ***
`timescale 1ns/10ps
// ==========================================
// analog side: held input against the dac
module sarhp_comp_model
    import sarhp_pkg::*;
(
    input wire logic [11:0] level, // held input code
    input wire logic [11:0] dac_code, // trial code
    output logic comp_above // input at or above trial
);
    // ideal comparator, so the search lands on level
    assign comp_above = (level >= dac_code);
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
// ==========================================
// testbench top
module tb_top import sarhp_pkg::*;;
    localparam int CONV_LOW = FIRST_DECIDE_CYCLES + RES_BITS * STEP_CYCLES + 1;
    logic clock, rst_n, cs_n, conv_start_n, rd_n, sleep_n, nap_n;
    logic upper_byte_sel, byte_mode, bipolar, big_bypass, comp_above;
    logic busy_n, ref_settled;
    logic [11:0] level, dac_code, data_out, data_oe, d, oe;
    int fails, tests_run, n;
    sarhp_ctrl #(.REF_BIG_CYCLES(20), .REF_SMALL_CYCLES(10)) u_sarhp_ctrl (
        .clock(clock), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
        .conv_start_n(conv_start_n), .sleep_n(sleep_n), .nap_n(nap_n),
        .upper_byte_sel(upper_byte_sel), .byte_mode(byte_mode),
        .bipolar(bipolar), .big_bypass(big_bypass), .comp_above(comp_above),
        .dac_code(dac_code), .busy_n(busy_n), .ref_settled(ref_settled),
        .data_out(data_out), .data_oe(data_oe));
    sarhp_comp_model u_sarhp_comp_model (.level(level),
        .dac_code(dac_code), .comp_above(comp_above));
    // 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic stop_test();
        if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [11:0] e, g);
        tests_run++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // bounded wait: sel 0 busy, sel 1 ref ready
    task automatic wait_sig(input bit sel, input logic v, output int c);
        c = 0;
        do begin
            @(posedge clock);
            #1;
            c++;
        end while ((sel ? ref_settled : busy_n) !== v && c < 400);
        if (c >= 400) begin
            fails++;
            stop_test();
        end
    endtask
    task automatic pulse();
        @(posedge clock) conv_start_n <= 1'b0;
        @(posedge clock) conv_start_n <= 1'b1; // short low
    endtask
    task automatic rd(input logic hi);
        @(posedge clock) {rd_n, upper_byte_sel} <= {1'b0, hi};
        @(posedge clock);
        #1;
        d = data_out;
        oe = data_oe;
        @(posedge clock) rd_n <= 1'b1;
    endtask
    task automatic conv(input logic [11:0] lv, input int extra);
        @(posedge clock) level <= lv;
        repeat (40) @(posedge clock); // acquisition gap
        pulse();
        wait_sig(0, 0, n);
        repeat (extra) pulse(); // extra starts while busy
        wait_sig(0, 1, n);
        // count starts one edge after busy fell, minus the extra pulses
        cmp("busy low", 12'(CONV_LOW - 1 - 2 * extra), 12'(n));
    endtask
    task automatic t_word();
        logic [11:0] v [3] = '{12'h000, 12'hfff, 12'ha5c};
        foreach (v[i]) begin
            conv(v[i], i);
            rd(0); // result taken once busy has risen
            cmp("word", v[i], d);
            cmp("word oe", 12'hfff, oe);
        end
    endtask
    task automatic t_cs();
        @(posedge clock) cs_n <= 1'b1;
        pulse();
        rd(0);
        #1;
        cmp("busy cs high", 12'h001, 12'(busy_n));
        cmp("oe cs high", 12'h000, oe);
        @(posedge clock) cs_n <= 1'b0;
    endtask
    task automatic t_byte();
        // full word in bipolar range: twos complement, msb flipped
        @(posedge clock) bipolar <= 1'b1;
        conv(12'h9e7, 0);
        rd(0);
        cmp("bipolar word", 12'h1e7, d);
        @(posedge clock) byte_mode <= 1'b1;
        conv(12'h9e7, 0);
        rd(0);
        cmp("low byte", 12'h0e7, d);
        cmp("byte oe", 12'h0ff, oe);
        rd(1);
        cmp("high byte", 12'h009, d);
    endtask
    // power-down: starts refused, then a clean wake
    task automatic t_power(input bit deep);
        @(posedge clock) {sleep_n, nap_n, big_bypass} <= {!deep, deep, 1'b1};
        pulse();
        @(posedge clock) {sleep_n, nap_n} <= 2'b11;
        pulse();
        repeat (2) @(posedge clock);
        #1;
        cmp("busy waking", 12'h001, 12'(busy_n));
        cmp("ref waking", 12'(!deep), 12'(ref_settled));
        wait_sig(1, 1, n);
        conv(12'h07f, 0);
        rd(0);
        cmp("wake word", 12'h07f, d);
    endtask
    initial begin
        {fails, tests_run} = '0;
        {rst_n, cs_n, rd_n, upper_byte_sel, byte_mode} = 5'b00100;
        {conv_start_n, sleep_n, nap_n, bipolar, big_bypass} = 5'b11100;
        level = 12'h000;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        wait_sig(1, 1, n);
        t_word();
        t_cs();
        t_byte();
        t_power(0);
        t_power(1);
        stop_test();
    end
endmodule
